/* File: logic/op_exec_regs.vh */
`ifndef OP_EXEC_REGS_VH
`define OP_EXEC_REGS_VH

// Operation codes on the issue port
`define OPC_NONE       2'h0
`define OPC_AND_MEM    2'h1
`define OPC_CALL       2'h2
`define OPC_ZERO_MEM   2'h3

// Status word bit positions
`define FLG_CARRY_BIT  0
`define FLG_HALF_BIT   1
`define FLG_ZERO_BIT   2
`define FLG_WRAP_BIT   3
`define FLG_PDOWN_BIT  4
`define FLG_WDOG_BIT   5

// Reset values
`define RST_STATUS     6'h00
`define RST_BYTE       8'h00
`define RST_PC         12'h000
`define RST_ADDR       8'h00
`define RST_STROBE     1'h0

// Return address step
`define PC_STEP        12'h001

`endif

/* File: logic/op_alu.v */
`timescale 1ns/1ps
`default_nettype none
`include "op_exec_regs.vh"

module op_alu #(
    parameter W = 8
) (
    input  wire [1:0]   i_op,       // Operation code
    input  wire [W-1:0] i_acc,      // Accumulator
    input  wire [W-1:0] i_mem,      // Memory operand
    output reg  [W-1:0] o_res,      // Byte to write back
    output wire         o_zero      // Result is zero
);
    always @* begin
        case (i_op)
            `OPC_AND_MEM:  o_res = i_acc & i_mem;
            `OPC_ZERO_MEM: o_res = {W{1'b0}};
            default:       o_res = i_mem;
        endcase
    end

    assign o_zero = (o_res == {W{1'b0}});
endmodule

`default_nettype wire

/* File: logic/op_exec.v */
`timescale 1ns/1ps
`default_nettype none
`include "op_exec_regs.vh"

module op_exec #(
    parameter DW = 8,
    parameter AW = 8,
    parameter PW = 12
) (
    input  wire          I_CLK_SYS,      // System clock
    input  wire          I_RESETN,       // Synchronous reset, active low
    input  wire          I_CE,           // Clock enable
    input  wire          I_ISSUE,        // Start an operation, one cycle
    input  wire [1:0]    I_OP,           // Operation code
    input  wire [AW-1:0] I_ADDR,         // Data memory address
    input  wire [PW-1:0] I_TARGET,       // Call target
    input  wire [PW-1:0] I_PC,           // Current program counter
    input  wire [DW-1:0] I_ACC,          // Accumulator
    input  wire [5:0]    I_STATUS,       // Status word in
    input  wire [DW-1:0] I_MEM_RDATA,    // Memory read data, next cycle
    output wire          O_MEM_RD,       // Memory read strobe
    output wire [AW-1:0] O_MEM_ADDR,     // Memory address
    output wire          O_MEM_WR,       // Memory write strobe
    output wire [DW-1:0] O_MEM_WDATA,    // Memory write data
    output wire          O_PUSH,         // Stack push strobe
    output wire [PW-1:0] O_PUSH_DATA,    // Return address
    output wire          O_PC_LOAD,      // Program counter load strobe
    output wire [PW-1:0] O_PC_NEXT,      // New program counter
    output wire          O_STATUS_WR,    // Status write strobe
    output wire [5:0]    O_STATUS,       // Status word out
    output wire          O_BUSY,         // Operation in progress
    output wire          O_DONE          // Operation finished, one cycle
);
    // ********************************
    // State
    // ********************************
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_WB   = 3'h4;

    // Registered state and its next values
    reg  [2:0]    state_q;
    reg  [2:0]    state_d;
    reg  [1:0]    op_q;
    reg  [1:0]    op_d;
    reg  [AW-1:0] addr_q;
    reg  [AW-1:0] addr_d;
    reg  [DW-1:0] acc_q;
    reg  [DW-1:0] acc_d;
    reg  [5:0]    stat_q;
    reg  [5:0]    stat_d;
    reg           busy_q;
    reg           busy_d;
    reg           rd_q;
    reg           rd_d;
    reg           wr_q;
    reg           wr_d;
    reg  [DW-1:0] wdata_q;
    reg  [DW-1:0] wdata_d;
    reg           push_q;
    reg           push_d;
    reg  [PW-1:0] push_data_q;
    reg  [PW-1:0] push_data_d;
    reg           pcl_q;
    reg           pcl_d;
    reg  [PW-1:0] pc_next_q;
    reg  [PW-1:0] pc_next_d;
    reg           swr_q;
    reg           swr_d;
    reg  [5:0]    stat_out_q;
    reg  [5:0]    stat_out_d;
    reg           done_q;
    reg           done_d;

    wire          take;
    wire [1:0]    alu_op;
    wire [DW-1:0] alu_res;
    wire          alu_zero;
    wire [PW-1:0] ret_addr;
    wire [5:0]    flags_and;

    // ********************************
    // Operand logic
    // ********************************
    // Issue while busy is dropped, not queued
    assign take     = I_ISSUE & ~busy_q;
    // Zero-memory resolves at issue, AND only after the read returns
    assign alu_op   = busy_q ? op_q : I_OP;
    assign ret_addr = I_PC + `PC_STEP;

    op_alu #(
        .W      (DW)
    ) u_alu (
        .i_op   (alu_op),
        .i_acc  (acc_q),
        .i_mem  (I_MEM_RDATA),
        .o_res  (alu_res),
        .o_zero (alu_zero)
    );

    // Only the zero bit follows the result; the rest pass through
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_flag
            if (g == `FLG_ZERO_BIT) begin : g_zero
                assign flags_and[g] = alu_zero;
            end else begin : g_keep
                assign flags_and[g] = stat_q[g];
            end
        end
    endgenerate

    // ********************************
    // Next state
    // ********************************
    always @* begin
        state_d     = state_q;
        op_d        = op_q;
        addr_d      = addr_q;
        acc_d       = acc_q;
        stat_d      = stat_q;
        busy_d      = busy_q;
        wdata_d     = wdata_q;
        push_data_d = push_data_q;
        pc_next_d   = pc_next_q;
        stat_out_d  = stat_out_q;
        // Strobes last one enabled cycle
        rd_d        = 1'h0;
        wr_d        = 1'h0;
        push_d      = 1'h0;
        pcl_d       = 1'h0;
        swr_d       = 1'h0;
        done_d      = 1'h0;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    op_d   = I_OP;
                    addr_d = I_ADDR;
                    acc_d  = I_ACC;
                    stat_d = I_STATUS;
                    case (I_OP)
                        `OPC_AND_MEM: begin
                            rd_d    = 1'h1;
                            busy_d  = 1'h1;
                            state_d = ST_READ;
                        end
                        `OPC_CALL: begin
                            // No condition is examined
                            push_d      = 1'h1;
                            push_data_d = ret_addr;
                            pcl_d       = 1'h1;
                            pc_next_d   = I_TARGET;
                            swr_d       = 1'h0;
                            done_d      = 1'h1;
                        end
                        `OPC_ZERO_MEM: begin
                            wr_d    = 1'h1;
                            wdata_d = alu_res;
                            swr_d   = 1'h0;
                            done_d  = 1'h1;
                        end
                        default: begin
                            // Empty code starts nothing and never completes
                            done_d = 1'h0;
                        end
                    endcase
                end
            end
            ST_READ: begin
                // Memory answers one cycle after the read strobe
                state_d = ST_WB;
            end
            ST_WB: begin
                wr_d       = 1'h1;
                wdata_d    = alu_res;
                swr_d      = 1'h1;
                stat_out_d = flags_and;
                done_d     = 1'h1;
                busy_d     = 1'h0;
                state_d    = ST_IDLE;
            end
            default: begin
                busy_d  = 1'h0;
                state_d = ST_IDLE;
            end
        endcase
    end

    // ********************************
    // Registers
    // ********************************
    always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            state_q     <= ST_IDLE;
            op_q        <= `OPC_NONE;
            addr_q      <= `RST_ADDR;
            acc_q       <= `RST_BYTE;
            stat_q      <= `RST_STATUS;
            busy_q      <= `RST_STROBE;
            rd_q        <= `RST_STROBE;
            wr_q        <= `RST_STROBE;
            wdata_q     <= `RST_BYTE;
            push_q      <= `RST_STROBE;
            push_data_q <= `RST_PC;
            pcl_q       <= `RST_STROBE;
            pc_next_q   <= `RST_PC;
            swr_q       <= `RST_STROBE;
            stat_out_q  <= `RST_STATUS;
            done_q      <= `RST_STROBE;
        end else if (I_CE) begin
            // Low enable freezes everything, strobes included
            state_q     <= state_d;
            op_q        <= op_d;
            addr_q      <= addr_d;
            acc_q       <= acc_d;
            stat_q      <= stat_d;
            busy_q      <= busy_d;
            rd_q        <= rd_d;
            wr_q        <= wr_d;
            wdata_q     <= wdata_d;
            push_q      <= push_d;
            push_data_q <= push_data_d;
            pcl_q       <= pcl_d;
            pc_next_q   <= pc_next_d;
            swr_q       <= swr_d;
            stat_out_q  <= stat_out_d;
            done_q      <= done_d;
        end
    end

    assign O_MEM_RD    = rd_q;
    assign O_MEM_ADDR  = addr_q;
    assign O_MEM_WR    = wr_q;
    assign O_MEM_WDATA = wdata_q;
    assign O_PUSH      = push_q;
    assign O_PUSH_DATA = push_data_q;
    assign O_PC_LOAD   = pcl_q;
    assign O_PC_NEXT   = pc_next_q;
    assign O_STATUS_WR = swr_q;
    assign O_STATUS    = stat_out_q;
    assign O_BUSY      = busy_q;
    assign O_DONE      = done_q;
endmodule

`default_nettype wire

/* File: sim/op_exec_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module op_exec_asserts (
    input wire logic        I_CLK_SYS,   // Clock
    input wire logic        I_RESETN,    // Reset
    input wire logic        I_CE,        // Enable
    input wire logic        I_ISSUE,     // Start
    input wire logic [1:0]  I_OP,        // Op
    input wire logic [11:0] I_TARGET,    // Target
    input wire logic [11:0] I_PC,        // Counter
    input wire logic [7:0]  I_ACC,       // Acc
    input wire logic [5:0]  I_STATUS,    // Flags in
    input wire logic [7:0]  I_MEM_RDATA, // Rdata
    input wire logic        O_BUSY,      // Busy
    input wire logic        O_MEM_WR,    // Write
    input wire logic [7:0]  O_MEM_WDATA, // Wdata
    input wire logic        O_PUSH,      // Push
    input wire logic [11:0] O_PUSH_DATA, // Return
    input wire logic        O_PC_LOAD,   // Load
    input wire logic [11:0] O_PC_NEXT,   // New pc
    input wire logic        O_STATUS_WR, // Flags wr
    input wire logic [5:0]  O_STATUS     // Flags out
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);
    wire iss = I_CE && I_ISSUE && !O_BUSY;
    property p_and;
        iss && I_OP == 2'h1 |-> ##3 O_MEM_WR && O_MEM_WDATA == ($past(I_ACC, 3) & $past(I_MEM_RDATA));
    endproperty
    a_and: assert property (p_and) else $error("and write-back wrong");
    // Zero follows the written byte, others pass through untouched
    property p_flg;
        iss && I_OP == 2'h1 |-> ##3 O_STATUS_WR && O_STATUS[2] == (O_MEM_WDATA == 8'h00)
            && (O_STATUS & 6'h3b) == ($past(I_STATUS, 3) & 6'h3b);
    endproperty
    a_flg: assert property (p_flg) else $error("and flags wrong");
    property p_push;
        iss && I_OP == 2'h2 |=> O_PUSH && O_PUSH_DATA == $past(I_PC) + 12'h001;
    endproperty
    a_push: assert property (p_push) else $error("return address wrong");
    property p_jmp;
        iss && I_OP == 2'h2 |=> O_PC_LOAD && O_PC_NEXT == $past(I_TARGET);
    endproperty
    a_jmp: assert property (p_jmp) else $error("call target wrong");
    property p_clr;
        iss && I_OP == 2'h3 |=> O_MEM_WR && O_MEM_WDATA == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("clear wrong");
    property p_keep;
        iss && I_OP[1] |=> !O_STATUS_WR;
    endproperty
    a_keep: assert property (p_keep) else $error("flags touched");
    c_and: cover property (iss && I_OP == 2'h1);
    c_call: cover property (iss && I_OP == 2'h2);
    c_clr: cover property (iss && I_OP == 2'h3);
endmodule
`default_nettype wire

/* File: sim/op_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module op_mem_model (
    input  wire logic       clk,   // Clock
    input  wire logic       rd,    // Read strobe
    input  wire logic       wr,    // Write strobe
    input  wire logic [7:0] addr,  // Address
    input  wire logic [7:0] wdata, // Write data
    output var  logic [7:0] rdata  // Read data
);
    logic [7:0] mem [256];
    initial begin
        rdata = 8'h00;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) * 8'h25;
    end
    // Inverted byte outside the read cycle, so a stale byte comes back on every second idle cycle
    always @(posedge clk) begin
        rdata <= rd ? mem[addr] : ~rdata;
        if (wr)
            mem[addr] <= wdata;
    end
endmodule
`default_nettype wire

/* File: sim/mcu_and_call_clear_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mcu_and_call_clear_exec_tb;
    logic clk = 0, rstn = 0, iss = 0, ce = 1, mrd, wr, psh, pld, swr, busy, done;
    logic [1:0] op = 0;
    logic [7:0] adr = 0, acc = 0, rd, wd, ma, e, sh [256];
    logic [11:0] pc = 0, tg = 0, pd, pn;
    logic [5:0] st = 0, so, es;
    int errors = 0, comparisons = 0, cyc = 0, r = 72656, n;
    always #5 clk = ~clk;
    op_exec uut (
        .I_CLK_SYS(clk), .I_RESETN(rstn), .I_CE(ce), .I_ISSUE(iss), .I_OP(op),
        .I_ADDR(adr), .I_TARGET(tg), .I_PC(pc), .I_ACC(acc), .I_STATUS(st),
        .I_MEM_RDATA(rd), .O_MEM_RD(mrd), .O_MEM_ADDR(ma), .O_MEM_WR(wr),
        .O_MEM_WDATA(wd), .O_PUSH(psh), .O_PUSH_DATA(pd), .O_PC_LOAD(pld),
        .O_PC_NEXT(pn), .O_STATUS_WR(swr), .O_STATUS(so), .O_BUSY(busy), .O_DONE(done)
    );
    op_mem_model mdl (.clk(clk), .rd(mrd), .wr(wr), .addr(ma), .wdata(wd), .rdata(rd));
    function automatic int xs();
        r = r ^ (r << 13);
        r = r ^ (r >> 17);
        r = r ^ (r << 5);
        return r;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    task automatic step();
        iss = 1;
        @(negedge clk);
        iss = 0;
        chk({mrd, busy}, {op == 2'h1, op == 2'h1});
        n = 0;
        while (done !== 1'b1 && n < 5) begin
            @(negedge clk);
            n++;
        end
        e = acc & sh[adr];
        es = {st[5:3], e == 8'h00, st[1:0]};
        case (op)
            2'h0: chk({done, mrd, wr, psh, pld, swr}, 6'h00);
            2'h1: chk({wr, ma, wd, swr, so}, {1'h1, adr, e, 1'h1, es});
            2'h2: chk({psh, pd, pld, pn}, {1'h1, pc + 12'h001, 1'h1, tg});
            2'h3: chk({wr, ma, wd}, {1'h1, adr, 8'h00});
        endcase
        if (op[1])
            chk(swr, 1'h0);
        if (op != 2'h0)
            chk({done, busy, 8'(n)}, {2'h2, op == 2'h1 ? 8'h02 : 8'h00});
        if (op[0])
            sh[adr] = op[1] ? 8'h00 : e;
    endtask
    initial begin
        for (int i = 0; i < 256; i++)
            sh[i] = 8'(i) * 8'h25;
        repeat (4) @(negedge clk);
        rstn = 1;
        for (int k = 0; k < 80; k++) begin
            @(negedge clk);
            {pc, tg, st, acc, adr, op} = 48'({xs(), xs()});
            step();
        end
        // An issue held while the enable is low waits for it
        @(negedge clk);
        op = 2'h2;
        ce = 0;
        iss = 1;
        repeat (3) @(negedge clk);
        chk({psh, pld, done, busy}, 4'h0);
        ce = 1;
        step();
        // Low enable holds the strobes as well
        ce = 0;
        @(negedge clk);
        chk({psh, pld, done}, 3'h7);
        ce = 1;
        // Reset in the middle of an AND, then issue at the first edge after
        @(negedge clk);
        op = 2'h1;
        iss = 1;
        @(negedge clk);
        iss = 0;
        rstn = 0;
        @(negedge clk);
        chk({mrd, busy, wr, swr, psh, pld, done, ma}, 15'h0000);
        chk({so, pd, pn}, 30'h0000_0000);
        rstn = 1;
        step();
        results();
    end
endmodule
bind op_exec op_exec_asserts chk_i (.*);
`default_nettype wire
